//--- testbench/ncd_exec_props.sv
// concurrent checks on the executor ports
`timescale 1ns/10ps
module ncd_exec_props
    import ncd_pkg::*;
#(
    parameter int RAM_WORDS = 512,
    parameter int ROM_AW = 13
)
(
    // clock, reset, instruction stream
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [NCD_IW-1:0] instrWord,
    input wire logic instrValid,
    input wire logic busy,
    // memory ports and state
    input wire logic [10:0] ramAddr,
    input wire logic [NCD_NW-1:0] ramRdata,
    input wire logic [NCD_NW-1:0] ramWdata,
    input wire logic ramWe,
    input wire logic [ROM_AW-1:0] romAddr,
    input wire logic romRd,
    input wire logic skipNext,
    input wire logic [NCD_NW-1:0] workNibble,
    input wire logic [NCD_NW-1:0] highHalfAcc,
    input wire logic carryBit,
    input wire logic [2:0] tablePageBits,
    input wire logic [3:0] ramFileIndex,
    input wire logic [3:0] ramDigitIndex
);
    logic take;
    logic prevLoadAcc_r;
    logic imm2_r;
    logic [10:0] addrQ_r;
    logic [NCD_NW-1:0] memNow;
    // operand word of the compare-immediate is no instruction of its own
    assign take = instrValid && !busy && !imm2_r;
    always_ff @(posedge mclk)
        imm2_r <= !sys_rst && (imm2_r ? !instrValid : take && instrWord == OP_SKIP_EQ_IMM);
    // idle cycles do not break a run, only other valid words do
    always_ff @(posedge mclk)
        if (sys_rst || instrValid)
            prevLoadAcc_r <= !sys_rst && take && instrWord[9:4] == PFX_LOAD_ACC;
    // ram contents as seen now: a write lands one edge after its instruction
    always_ff @(posedge mclk)
        addrQ_r <= ramAddr;
    assign memNow = (ramWe && addrQ_r == ramAddr) ? ramWdata : ramRdata;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    property p_bToAcc;
        take && instrWord == OP_B_TO_ACC |=> workNibble == $past(highHalfAcc) && $stable(carryBit);
    endproperty
    a_bToAcc: assert property (p_bToAcc) else $error("b to acc copy wrong");
    property p_incDigit;
        take && instrWord == OP_INC_DIGIT |=> ramDigitIndex == $past(ramDigitIndex) + 4'h1
            && skipNext == (ramDigitIndex == 4'h0);
    endproperty
    a_incDigit: assert property (p_incDigit) else $error("digit increment wrong");
    property p_decDigit;
        take && instrWord == OP_DEC_DIGIT |=> ramDigitIndex == $past(ramDigitIndex) - 4'h1
            && skipNext == (ramDigitIndex == 4'hf);
    endproperty
    a_decDigit: assert property (p_decDigit) else $error("digit decrement wrong");
    property p_ramToAcc;
        take && instrWord[9:4] == PFX_RAM_TO_ACC |=> workNibble == $past(memNow)
            && ramFileIndex == ($past(ramFileIndex) ^ $past(instrWord[3:0]));
    endproperty
    a_ramToAcc: assert property (p_ramToAcc) else $error("ram to acc wrong");
    property p_accToRam;
        take && instrWord[9:4] == PFX_ACC_TO_RAM |=> ramWe && ramWdata == $past(workNibble);
    endproperty
    a_accToRam: assert property (p_accToRam) else $error("acc to ram write wrong");
    property p_sumCarry;
        take && instrWord == OP_SUM_CARRY |=> {carryBit, workNibble} ==
            5'($past(workNibble)) + 5'($past(memNow)) + 5'($past(carryBit));
    endproperty
    a_sumCarry: assert property (p_sumCarry) else $error("add with carry wrong");
    property p_loadAcc;
        take && instrWord[9:4] == PFX_LOAD_ACC |=>
            workNibble == ($past(prevLoadAcc_r) ? $past(workNibble) : $past(instrWord[3:0]));
    endproperty
    a_loadAcc: assert property (p_loadAcc) else $error("acc immediate load wrong");
    property p_table;
        take && instrWord[9:6] == PFX_TABLE |=> romRd
            && romAddr == {$past(instrWord[5:0]), $past(tablePageBits), $past(workNibble)};
    endproperty
    a_table: assert property (p_table) else $error("table fetch address wrong");
    c_loadAccRun: cover property (take && instrWord[9:4] == PFX_LOAD_ACC && prevLoadAcc_r);
    c_table: cover property (romRd);
    c_skip: cover property (skipNext);
endmodule : ncd_exec_props

//--- testbench/ncd_exec_tb_top.sv
// self-checking bench for the nibble cpu data-operation executor
`timescale 1ns/10ps
module ncd_exec_tb_top;
    import ncd_pkg::*;
    localparam int W = 1, B = 2, E = 3, D = 4, YS = 5, XY = 6, CW = 7, S = 8;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic instrValid = 1'b0;
    logic [9:0] instrWord = 10'h0;
    logic [2:0] callStackPtr = 3'h5;
    logic [10:0] ramAddr;
    logic [12:0] romAddr;
    logic [9:0] romData;
    logic [7:0] wordHolding;
    logic [3:0] ramRdata, ramWdata, workNibble, highHalfAcc, ramFileIndex, ramDigitIndex;
    logic [2:0] tablePageBits;
    logic [1:0] ramBankIndex;
    logic ramWe, romRd, skipNext, busy, carryBit;
    string nm [9] = '{"none", "acc", "b", "e", "page", "digit_skip", "file_digit",
        "carry_acc", "skip"};
    int num_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    ncd_exec dut (.mclk, .sys_rst, .instrWord, .instrValid, .callStackPtr, .ramAddr, .ramRdata,
        .ramWdata, .ramWe, .romAddr, .romRd, .romData, .skipNext, .busy, .workNibble,
        .highHalfAcc, .carryBit, .wordHolding, .tablePageBits, .ramBankIndex, .ramFileIndex,
        .ramDigitIndex);
    ncd_mem_model u_mem (.clk(mclk), .ramAddr, .ramWdata, .ramWe, .ramRdata, .romAddr, .romRd,
        .romData);
    always #12.5 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out
    task automatic ck(input string n, input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : ck
    // one word, or two on back-to-back cycles, then a look mid-cycle while pulses stand
    task automatic st(input logic [9:0] a, input int s, input logic [7:0] e,
        input logic [9:0] b = 10'h0, input bit two = 1'b0);
        logic [7:0] v [9];
        @(posedge mclk);
        instrWord <= a;
        instrValid <= 1'b1;
        @(posedge mclk);
        if (two)
        begin
            instrWord <= b;
            @(posedge mclk);
        end
        instrValid <= 1'b0;
        @(negedge mclk);
        v = '{8'h0, workNibble, highHalfAcc, wordHolding, tablePageBits,
            {ramDigitIndex, 3'h0, skipNext}, {ramFileIndex, ramDigitIndex},
            {carryBit, workNibble}, skipNext};
        if (s > 0)
            ck(nm[s], v[s], e);
    endtask : st
    task automatic t_xfer();
        st({PFX_LOAD_ACC, 4'h5}, W, 8'h5);
        st(OP_ACC_TO_B, B, 8'h5);
        st({PFX_LOAD_ACC, 4'ha}, W, 8'ha);
        st(OP_PACK, E, 8'h5a);
        st(OP_B_TO_ACC, CW, 8'h05);
        st(OP_UNPACK, W, 8'ha);
        st(OP_ACC_TO_TBL, D, 8'h2);
        st({PFX_LOAD_ACC, 4'hf}, 0, 8'h0);
        st(OP_TBL_TO_ACC, W, 8'h2);
        st(OP_ACC_TO_DIGIT, YS, 8'h20);
        st({PFX_LOAD_BANK, 2'h3}, 0, 8'h0);
        st(OP_BANK_TO_ACC, W, 8'h3);
        st(OP_STACK_TO_ACC, W, 8'h5);
        st(OP_FILE_TO_ACC, W, 8'h0);
        st(OP_DIGIT_TO_ACC, W, 8'h2);
        st({PFX_LOAD_ACC, 4'h1}, W, 8'h1, {PFX_LOAD_ACC, 4'h9}, 1'b1);
        $display("test transfers done");
    endtask : t_xfer
    task automatic t_ram();
        st({PFX_LOAD_PAIR, 8'h0f}, XY, 8'h0f);
        st(OP_INC_DIGIT, YS, 8'h01);
        st(OP_INC_DIGIT, YS, 8'h10);
        st(OP_DEC_DIGIT, YS, 8'h00);
        st(OP_DEC_DIGIT, YS, 8'hf1);
        st({PFX_LOAD_PAIR, 8'h34}, XY, 8'h34, {PFX_LOAD_PAIR, 8'h67}, 1'b1);
        st({PFX_LOAD_ACC, 4'h9}, 0, 8'h0);
        st({PFX_ACC_TO_RAM, 4'h3}, XY, 8'h04);
        st({PFX_RAM_TO_ACC, 4'h3}, W, 8'h6);
        st({PFX_SWAP, 4'h0}, W, 8'h9);
        st({PFX_RAM_TO_ACC, 4'h0}, W, 8'h6);
        st(OP_CLR_CARRY, 0, 8'h0);
        st(OP_SUM, CW, 8'h0c);
        st(OP_SET_CARRY, 0, 8'h0);
        st(OP_SUM_CARRY, CW, 8'h13);
        st(OP_AND, W, 8'h2);
        st(OP_OR, W, 8'h6);
        st({PFX_SET_BIT, 2'h0}, 0, 8'h0);
        st({PFX_CLR_BIT, 2'h1}, 0, 8'h0);
        st({PFX_SKIP_BIT, 2'h1}, S, 8'h1);
        st({PFX_SKIP_BIT, 2'h0}, S, 8'h0);
        st(OP_SKIP_EQ_RAM, S, 8'h0);
        st({PFX_LOAD_ACC, 4'h5}, 0, 8'h0);
        st(OP_SKIP_EQ_RAM, S, 8'h1);
        st(OP_SKIP_EQ_IMM, S, 8'h1, {PFX_LOAD_ACC, 4'h5}, 1'b1);
        st(OP_SKIP_EQ_IMM, S, 8'h0, {PFX_LOAD_ACC, 4'h4}, 1'b1);
        st({PFX_LOAD_PAIR, 8'h30}, 0, 8'h0);
        st({PFX_SWAP_DEC, 4'h0}, YS, 8'hf1);
        st({PFX_SWAP_INC, 4'h0}, YS, 8'h01);
        st({PFX_LOAD_ACC, 4'hb}, 0, 8'h0);
        st({PFX_ACC_TO_RAM, 4'h0}, W, 8'hb, {PFX_RAM_TO_ACC, 4'h0}, 1'b1);
        $display("test ram and index done");
    endtask : t_ram
    task automatic t_alu();
        logic [9:0] d;
        d = {3'h3, 3'h5, 4'hc} ^ 10'h2a5;
        st(OP_SKIP_CARRY_CLR, S, 8'h0);
        st(OP_CLR_CARRY, 0, 8'h0);
        st(OP_SKIP_CARRY_CLR, S, 8'h1);
        st({PFX_LOAD_ACC, 4'h6}, 0, 8'h0);
        st(OP_INVERT, W, 8'h9);
        st(OP_SET_CARRY, 0, 8'h0);
        st(OP_ROTATE, CW, 8'h1c);
        st(OP_ROTATE, CW, 8'h0e);
        st({PFX_ADD_IMM, 4'h1}, S, 8'h1);
        st({PFX_ADD_IMM, 4'h3}, CW, 8'h02);
        st({PFX_LOAD_ACC, 4'h5}, 0, 8'h0);
        st(OP_ACC_TO_TBL, D, 8'h5);
        st({PFX_LOAD_ACC, 4'hc}, 0, 8'h0);
        st({PFX_TABLE, 6'h2b}, 0, 8'h0);
        ck("busy", {7'h0, busy}, 8'h1);
        for (int i = 0; i < 8 && busy !== 1'b0; i++)
            @(negedge mclk);
        @(negedge mclk);
        ck(nm[D], tablePageBits, {6'h0, d[9:8]});
        ck("b_acc", {highHalfAcc, workNibble}, d[7:0]);
        $display("test arithmetic and table done");
    endtask : t_alu
    initial
    begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        t_xfer();
        t_ram();
        t_alu();
        close_out();
    end
endmodule : ncd_exec_tb_top
bind ncd_exec ncd_exec_props #(.RAM_WORDS(RAM_WORDS), .ROM_AW(ROM_AW)) u_props (.mclk, .sys_rst,
    .instrWord, .instrValid, .busy, .ramAddr, .ramRdata, .ramWdata, .ramWe, .romAddr, .romRd,
    .skipNext, .workNibble, .highHalfAcc, .carryBit, .tablePageBits, .ramFileIndex,
    .ramDigitIndex);

//--- testbench/ncd_mem_model.sv
// data ram and table rom seen by the executor
`timescale 1ns/10ps
module ncd_mem_model
(
    // clock and ram side
    input wire logic clk,
    input wire logic [10:0] ramAddr,
    input wire logic [3:0] ramWdata,
    input wire logic ramWe,
    output logic [3:0] ramRdata,
    // rom side
    input wire logic [12:0] romAddr,
    input wire logic romRd,
    output logic [9:0] romData
);
    logic [3:0] mem [2048];
    logic [10:0] addrQ_r;
    logic [9:0] romQ_r = 10'h0;
    initial
        foreach (mem[i])
            mem[i] = 4'h6;
    assign ramRdata = mem[ramAddr];
    // write strobe lags, so the address of the instruction cycle is kept
    always @(posedge clk)
    begin
        addrQ_r <= ramAddr;
        if (ramWe)
            mem[addrQ_r] <= ramWdata;
    end
    // valid only in the cycle after a request, toggling otherwise to expose stale use
    always @(posedge clk)
        romQ_r <= romRd ? (romAddr[9:0] ^ 10'h2a5) : ~romQ_r;
    assign romData = romQ_r;
endmodule : ncd_mem_model

//--- verilog/ncd_exec.sv
// executor for nibble cpu transfer, arithmetic, bit and compare instructions
`timescale 1ns/10ps
// How it works
// RULE_01: copy B to acc, acc to B
// RULE_02: copy digit index to/from acc
// RULE_03: pack B and acc into word holding
// RULE_04: unpack word holding into B and acc
// RULE_05: acc low three bits to table page
// RULE_06: table page to acc, top bit zero
// RULE_07: bank index to acc, upper bits zero
// RULE_08: file index to acc
// RULE_09: stack pointer to acc, top bit zero
// RULE_10: load index pair; skip run followers
// RULE_11: load two-bit bank index
// RULE_12: increment digit; skip on zero
// RULE_13: decrement digit; skip on fifteen
// RULE_14: ram to acc, xor file index
// RULE_15: swap acc and ram, step variants
// RULE_16: acc to ram, xor file index
// RULE_17: add ram to acc, no carry
// RULE_18: add ram and carry, update carry
// RULE_19: and or with ram nibble
// RULE_20: set selected ram bit
// RULE_21: clear selected ram bit
// RULE_22: skip when ram bit clear
// RULE_23: load acc immediate; skip run followers
// RULE_24: rom table read in three cycles
// RULE_25: add immediate, skip on no overflow
// RULE_26: set, clear, test carry
// RULE_27: invert acc, rotate right through carry
// RULE_28: compare acc with ram or immediate
module ncd_exec
    import ncd_pkg::*;
#(
    parameter int RAM_WORDS = 512,
    parameter int ROM_AW = 13
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // instruction stream; instrValid marks a word to execute
    input wire logic [NCD_IW-1:0] instrWord,
    input wire logic instrValid,
    input wire logic [2:0] callStackPtr,
    // ram port, read data combinational from ramAddr
    output logic [10:0] ramAddr,
    input wire logic [NCD_NW-1:0] ramRdata,
    output logic [NCD_NW-1:0] ramWdata,
    output logic ramWe,
    // rom table read port, data one cycle after request
    output logic [ROM_AW-1:0] romAddr,
    output logic romRd,
    input wire logic [NCD_IW-1:0] romData,
    // sequencer hand-off
    output logic skipNext,
    output logic busy,
    // architectural state
    output logic [NCD_NW-1:0] workNibble,
    output logic [NCD_NW-1:0] highHalfAcc,
    output logic carryBit,
    output logic [7:0] wordHolding,
    output logic [2:0] tablePageBits,
    output logic [1:0] ramBankIndex,
    output logic [3:0] ramFileIndex,
    output logic [3:0] ramDigitIndex
);
    // the rom address needs 13 bits of page operand, page bits and acc
    if (ROM_AW < 13 || RAM_WORDS != 512)
    begin : g_sizeCheck
        $error("ncd_exec: unsupported ROM or RAM size");
    end

    ncd_state_e state_r;
    logic runLoadPair_r;
    logic runLoadAcc_r;
    logic [3:0] imm;
    logic [1:0] bitSel;
    logic [3:0] digitInc;
    logic [3:0] digitDec;
    logic [4:0] sumPlain;
    logic [4:0] sumCarry;
    logic [4:0] sumImm;
    logic isLoadPair;
    logic isLoadAcc;
    logic [5:0] pfx6;
    logic [7:0] pfx8;
    logic [10:0] wrAddr_r;
    logic [NCD_NW-1:0] memNibble;

    assign imm = instrWord[3:0];
    assign bitSel = instrWord[1:0];
    assign pfx6 = instrWord[9:4];
    assign pfx8 = instrWord[9:2];
    assign digitInc = ramDigitIndex + 4'h1;
    assign digitDec = ramDigitIndex - 4'h1;
    assign sumPlain = {1'b0, workNibble} + {1'b0, memNibble};
    assign sumCarry = {1'b0, workNibble} + {1'b0, memNibble} + {4'h0, carryBit};
    assign sumImm = {1'b0, workNibble} + {1'b0, imm};
    assign isLoadPair = (instrWord[9:8] == PFX_LOAD_PAIR);
    assign isLoadAcc = (pfx6 == PFX_LOAD_ACC);
    // data_pointer: bank, file, digit
    // top bit stays zero: the pointer spans 1024 nibbles
    assign ramAddr = {1'b0, ramBankIndex, ramFileIndex, ramDigitIndex}; // RULE_14

    // a write lands one edge after its instruction, so a word that
    // reads the same nibble right after it must take the written value
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            wrAddr_r <= '0;
        else
            wrAddr_r <= ramAddr;
    end
    assign memNibble = (ramWe && wrAddr_r == ramAddr) ? ramWdata : ramRdata;

    // no new word is taken while a table read or compare operand is pending
    logic exec;
    assign exec = instrValid && (state_r == NCD_RUN);

    // run tracking: a follower in a run of the same load is skipped
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            runLoadPair_r <= 1'b0;
            runLoadAcc_r <= 1'b0;
        end
        else if (exec)
        begin
            runLoadPair_r <= isLoadPair; // RULE_10
            runLoadAcc_r <= isLoadAcc; // RULE_23
        end
    end

    // run followers cost their cycle but change nothing
    logic suppress;
    assign suppress = (isLoadPair && runLoadPair_r) || (isLoadAcc && runLoadAcc_r);

    // sequencing: table read and two-word compare
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            state_r <= NCD_RUN;
        else
        begin
            case (state_r)
                NCD_RUN:
                    if (exec && instrWord[9:6] == PFX_TABLE)
                        state_r <= NCD_TBL_FETCH; // RULE_24
                    else if (exec && instrWord == OP_SKIP_EQ_IMM)
                        state_r <= NCD_IMM2; // RULE_28
                NCD_TBL_FETCH:
                    state_r <= NCD_TBL_LOAD;
                NCD_TBL_LOAD:
                    state_r <= NCD_RUN;
                // wait for the operand word, however late it comes
                NCD_IMM2:
                    if (instrValid)
                        state_r <= NCD_RUN;
                default:
                    state_r <= NCD_RUN;
            endcase
        end
    end

    // busy spans the fetch and load cycles after a table read
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            busy <= 1'b0;
        else
            busy <= (exec && instrWord[9:6] == PFX_TABLE) || (state_r == NCD_TBL_FETCH);
    end

    // rom request: page operand, page bits, acc low nibble
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            romAddr <= '0;
            romRd <= 1'b0;
        end
        else
        begin
            romRd <= exec && instrWord[9:6] == PFX_TABLE;
            if (exec && instrWord[9:6] == PFX_TABLE)
                romAddr <= ROM_AW'({instrWord[5:0], tablePageBits, workNibble}); // RULE_24
        end
    end

    // accumulator, B, carry, word holding, table page
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            workNibble <= '0;
            highHalfAcc <= '0;
            carryBit <= 1'b0;
            wordHolding <= '0;
            tablePageBits <= '0;
        end
        else if (state_r == NCD_TBL_LOAD)
        begin
            tablePageBits <= {1'b0, romData[9:8]}; // RULE_24
            highHalfAcc <= romData[7:4];
            workNibble <= romData[3:0];
        end
        else if (exec && !suppress)
        begin
            if (instrWord == OP_B_TO_ACC)
                workNibble <= highHalfAcc; // RULE_01
            else if (instrWord == OP_ACC_TO_B)
                highHalfAcc <= workNibble; // RULE_01
            else if (instrWord == OP_DIGIT_TO_ACC)
                workNibble <= ramDigitIndex; // RULE_02
            else if (instrWord == OP_PACK)
                wordHolding <= {highHalfAcc, workNibble}; // RULE_03
            else if (instrWord == OP_UNPACK)
            begin
                highHalfAcc <= wordHolding[7:4]; // RULE_04
                workNibble <= wordHolding[3:0];
            end
            else if (instrWord == OP_ACC_TO_TBL)
                tablePageBits <= workNibble[2:0]; // RULE_05
            else if (instrWord == OP_TBL_TO_ACC)
                workNibble <= {1'b0, tablePageBits}; // RULE_06
            else if (instrWord == OP_BANK_TO_ACC)
                workNibble <= {2'b00, ramBankIndex}; // RULE_07
            else if (instrWord == OP_FILE_TO_ACC)
                workNibble <= ramFileIndex; // RULE_08
            else if (instrWord == OP_STACK_TO_ACC)
                workNibble <= {1'b0, callStackPtr}; // RULE_09
            else if (pfx6 == PFX_RAM_TO_ACC)
                workNibble <= memNibble; // RULE_14
            else if (pfx6 == PFX_SWAP || pfx6 == PFX_SWAP_DEC || pfx6 == PFX_SWAP_INC)
                workNibble <= memNibble; // RULE_15
            else if (isLoadAcc)
                workNibble <= imm; // RULE_23
            else if (instrWord == OP_SUM)
                workNibble <= sumPlain[3:0]; // RULE_17
            else if (instrWord == OP_SUM_CARRY)
            begin
                workNibble <= sumCarry[3:0]; // RULE_18
                carryBit <= sumCarry[4];
            end
            else if (pfx6 == PFX_ADD_IMM)
                workNibble <= sumImm[3:0]; // RULE_25
            else if (instrWord == OP_AND)
                workNibble <= workNibble & memNibble; // RULE_19
            else if (instrWord == OP_OR)
                workNibble <= workNibble | memNibble; // RULE_19
            else if (instrWord == OP_SET_CARRY)
                carryBit <= 1'b1; // RULE_26
            else if (instrWord == OP_CLR_CARRY)
                carryBit <= 1'b0; // RULE_26
            else if (instrWord == OP_INVERT)
                workNibble <= ~workNibble; // RULE_27
            else if (instrWord == OP_ROTATE)
            begin
                workNibble <= {carryBit, workNibble[3:1]}; // RULE_27
                carryBit <= workNibble[0];
            end
        end
    end

    // ram address registers
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ramBankIndex <= '0;
            ramFileIndex <= '0;
            ramDigitIndex <= '0;
        end
        else if (exec && !suppress)
        begin
            if (isLoadPair)
            begin
                ramFileIndex <= instrWord[7:4]; // RULE_10
                ramDigitIndex <= instrWord[3:0];
            end
            else if (pfx8 == PFX_LOAD_BANK)
                ramBankIndex <= bitSel; // RULE_11
            else if (instrWord == OP_ACC_TO_DIGIT)
                ramDigitIndex <= workNibble; // RULE_02
            else if (instrWord == OP_INC_DIGIT)
                ramDigitIndex <= digitInc; // RULE_12
            else if (instrWord == OP_DEC_DIGIT)
                ramDigitIndex <= digitDec; // RULE_13
            else if (pfx6 == PFX_RAM_TO_ACC || pfx6 == PFX_SWAP || pfx6 == PFX_ACC_TO_RAM)
                ramFileIndex <= ramFileIndex ^ imm; // RULE_14 RULE_16
            else if (pfx6 == PFX_SWAP_DEC)
            begin
                ramFileIndex <= ramFileIndex ^ imm; // RULE_15
                ramDigitIndex <= digitDec;
            end
            else if (pfx6 == PFX_SWAP_INC)
            begin
                ramFileIndex <= ramFileIndex ^ imm; // RULE_15
                ramDigitIndex <= digitInc;
            end
        end
    end

    // ram write: swaps, store, bit set and clear
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            ramWe <= 1'b0;
            ramWdata <= '0;
        end
        else
        begin
            ramWe <= 1'b0;
            if (exec)
            begin
                if (pfx6 == PFX_SWAP || pfx6 == PFX_SWAP_DEC || pfx6 == PFX_SWAP_INC
                    || pfx6 == PFX_ACC_TO_RAM)
                begin
                    ramWe <= 1'b1; // RULE_15 RULE_16
                    ramWdata <= workNibble;
                end
                else if (pfx8 == PFX_SET_BIT)
                begin
                    ramWe <= 1'b1;
                    ramWdata <= memNibble | (4'h1 << bitSel); // RULE_20
                end
                else if (pfx8 == PFX_CLR_BIT)
                begin
                    ramWe <= 1'b1;
                    ramWdata <= memNibble & ~(4'h1 << bitSel); // RULE_21
                end
            end
        end
    end

    // skip decision for the following word; written ram address
    // is latched with the data since the pointer may move
    logic skipNow;
    always_comb
    begin
        skipNow = 1'b0;
        if (state_r == NCD_IMM2)
            skipNow = instrValid && (workNibble == imm); // RULE_28
        else if (exec && !suppress)
        begin
            if (instrWord == OP_INC_DIGIT || pfx6 == PFX_SWAP_INC)
                skipNow = (digitInc == DIGIT_WRAP_INC); // RULE_12 RULE_15
            else if (instrWord == OP_DEC_DIGIT || pfx6 == PFX_SWAP_DEC)
                skipNow = (digitDec == DIGIT_WRAP_DEC); // RULE_13 RULE_15
            else if (pfx6 == PFX_ADD_IMM)
                skipNow = !sumImm[4]; // RULE_25
            else if (instrWord == OP_SKIP_CARRY_CLR)
                skipNow = !carryBit; // RULE_26
            else if (pfx8 == PFX_SKIP_BIT)
                skipNow = !memNibble[bitSel]; // RULE_22
            else if (instrWord == OP_SKIP_EQ_RAM)
                skipNow = (workNibble == memNibble); // RULE_28
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
            skipNext <= 1'b0;
        else
            skipNext <= skipNow;
    end
endmodule : ncd_exec

//--- verilog/ncd_pkg.sv
// constants for the nibble cpu data-operation executor
package ncd_pkg;
    localparam int NCD_IW = 10;
    localparam int NCD_NW = 4;
    // opcode patterns, full 10-bit words
    localparam logic [9:0] OP_B_TO_ACC = 10'h01e;
    localparam logic [9:0] OP_ACC_TO_B = 10'h00e;
    localparam logic [9:0] OP_DIGIT_TO_ACC = 10'h01f;
    localparam logic [9:0] OP_ACC_TO_DIGIT = 10'h00c;
    localparam logic [9:0] OP_PACK = 10'h01a;
    localparam logic [9:0] OP_UNPACK = 10'h02a;
    localparam logic [9:0] OP_ACC_TO_TBL = 10'h029;
    localparam logic [9:0] OP_TBL_TO_ACC = 10'h051;
    localparam logic [9:0] OP_BANK_TO_ACC = 10'h053;
    localparam logic [9:0] OP_FILE_TO_ACC = 10'h052;
    localparam logic [9:0] OP_STACK_TO_ACC = 10'h050;
    localparam logic [9:0] OP_INC_DIGIT = 10'h013;
    localparam logic [9:0] OP_DEC_DIGIT = 10'h017;
    localparam logic [9:0] OP_SUM = 10'h00a;
    localparam logic [9:0] OP_SUM_CARRY = 10'h00b;
    localparam logic [9:0] OP_AND = 10'h018;
    localparam logic [9:0] OP_OR = 10'h019;
    localparam logic [9:0] OP_SET_CARRY = 10'h007;
    localparam logic [9:0] OP_CLR_CARRY = 10'h006;
    localparam logic [9:0] OP_SKIP_CARRY_CLR = 10'h02f;
    localparam logic [9:0] OP_INVERT = 10'h01c;
    localparam logic [9:0] OP_ROTATE = 10'h01d;
    localparam logic [9:0] OP_SKIP_EQ_RAM = 10'h026;
    localparam logic [9:0] OP_SKIP_EQ_IMM = 10'h025;
    // opcode prefixes with immediate fields below
    localparam logic [1:0] PFX_LOAD_PAIR = 2'h3;
    localparam logic [7:0] PFX_LOAD_BANK = 8'h12;
    localparam logic [5:0] PFX_RAM_TO_ACC = 6'h2c;
    localparam logic [5:0] PFX_SWAP = 6'h2d;
    localparam logic [5:0] PFX_SWAP_DEC = 6'h2f;
    localparam logic [5:0] PFX_SWAP_INC = 6'h2e;
    localparam logic [5:0] PFX_ACC_TO_RAM = 6'h2b;
    localparam logic [5:0] PFX_LOAD_ACC = 6'h07;
    localparam logic [5:0] PFX_ADD_IMM = 6'h06;
    localparam logic [3:0] PFX_TABLE = 4'h2;
    localparam logic [7:0] PFX_SET_BIT = 8'h17;
    localparam logic [7:0] PFX_CLR_BIT = 8'h13;
    localparam logic [7:0] PFX_SKIP_BIT = 8'h08;
    localparam logic [3:0] DIGIT_WRAP_DEC = 4'hf;
    localparam logic [3:0] DIGIT_WRAP_INC = 4'h0;
    localparam int TABLE_CYCLES = 3;
    typedef enum logic [1:0] {
        NCD_RUN = 2'b00,
        NCD_TBL_FETCH = 2'b01,
        NCD_TBL_LOAD = 2'b11,
        NCD_IMM2 = 2'b10
    } ncd_state_e;
endpackage : ncd_pkg
